// [core/accu_regs.svh]
`ifndef ACCU_REGS_SVH
`define ACCU_REGS_SVH

// Word addresses on the register port (6-bit word address)
`define ACCU_ADDR_W           6
`define ACCU_CNT_STRIDE       8
`define ACCU_ADDR_STATUS      6'h20
`define ACCU_ADDR_LATCH_CMD   6'h21
`define ACCU_ADDR_PERIOD_MEAS 6'h22

// Offsets inside one counter's group of eight words
`define ACCU_OFS_CNT          3'h0
`define ACCU_OFS_LATCH        3'h1
`define ACCU_OFS_CMP0         3'h2
`define ACCU_OFS_MAX          3'h5
`define ACCU_OFS_PRESET       3'h6
`define ACCU_OFS_CTL          3'h7

// Control word fields
`define ACCU_CTL_W            15
`define ACCU_CTL_EN_BIT       0
`define ACCU_CTL_RING_BIT     1
`define ACCU_CTL_RELOAD_BIT   2
`define ACCU_CTL_ACLR_BIT     3
`define ACCU_CTL_LCLR_BIT     4
`define ACCU_CTL_STOP_LSB     5
`define ACCU_CTL_CMPEN_LSB    7
`define ACCU_CTL_SRCA_LSB     10
`define ACCU_CTL_SRCB_LSB     12
`define ACCU_CTL_LPIN_BIT     14

// Status word fields: irq flags in the low nibble, comparator hits above
`define ACCU_STAT_HIT_LSB     4

// Pulse source codes
`define ACCU_SRC_NONE         2'h0
`define ACCU_SRC_DRIVE        2'h1
`define ACCU_SRC_FEEDBACK     2'h2
`define ACCU_SRC_AUX          2'h3

// Reset values
`define ACCU_RST_WORD         32'h0000_0000
`define ACCU_RST_CTL          15'h0000

// Reference clock timing
`define ACCU_MCLK_PERIOD_NS   25
`define ACCU_REF_PERIOD_NS    50
`define ACCU_REF_DIV          ((`ACCU_REF_PERIOD_NS + `ACCU_MCLK_PERIOD_NS - 1) / `ACCU_MCLK_PERIOD_NS)

`endif

// [core/accu_pkg.sv]
package accu_pkg;
    typedef logic [31:0] accu_word_t;
    typedef enum logic [1:0] {
        accu_stop_none,
        accu_stop_slow,
        accu_stop_fast,
        accu_stop_spare
    } accu_stop_e;
endpackage : accu_pkg

// [core/accu_top.sv]
// Notes on behaviour
// - 32-bit commanded position counts drive pulses.
// - Three commanded comparators raise commanded irq.
// - Match stops output slowly or at once.
// - 32-bit actual position counts feedback pulses.
// - Three actual comparators raise actual irq.
// - Difference counter: source A up, B down.
// - Three difference comparators raise difference irq.
// - One source selected gives plain pulse counter.
// - Period counter measures period in reference ticks.
// - Reference tick rate is 20 MHz.
// - Three period comparators raise period irq.
// - Period counter doubles as free 32-bit timer.
// - Latch event captures count, held till next.
// - Latch reads never disturb latch or count.
// - Clear-on-latch zeroes count at latch event.
// - First three counters wrap at programmable maximum.
// - First comparator match may reload preset data.
// - First comparator match may clear, not commanded.
`include "accu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module accu_top (
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic [`ACCU_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    input  wire logic                      drive_pulse,
    input  wire logic                      drive_dir,
    input  wire logic                      fb_up_pin,
    input  wire logic                      fb_dn_pin,
    input  wire logic                      aux_pulse_pin,
    input  wire logic                      latch_pin,
    output logic                           cmd_position_match_irq,
    output logic                           actual_position_match_irq,
    output logic                           difference_match_irq,
    output logic                           period_match_irq,
    output logic                           slow_stop,
    output logic                           fast_stop
);

    // Pin synchroniser: three stages, a level counts once stages two and three agree
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [3:0] pin_flt_r;
    logic [3:0] pin_flt_nxt;
    logic [3:0] pin_ev_r;

    assign pin_flt_nxt = (pin_s2_r & pin_s3_r) | (pin_flt_r & (pin_s2_r | pin_s3_r));

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_s1_r  <= 4'h0;
            pin_s2_r  <= 4'h0;
            pin_s3_r  <= 4'h0;
            pin_flt_r <= 4'h0;
            pin_ev_r  <= 4'h0;
        end else begin
            pin_s1_r  <= {latch_pin, aux_pulse_pin, fb_dn_pin, fb_up_pin};
            pin_s2_r  <= pin_s1_r;
            pin_s3_r  <= pin_s2_r;
            pin_flt_r <= pin_flt_nxt;
            pin_ev_r  <= pin_flt_nxt & ~pin_flt_r;  // Rising edge, one cycle
        end
    end

    // Named pulse events, all one cycle wide on mclk
    logic       fb_up_ev;
    logic       fb_dn_ev;
    logic       aux_ev;
    logic       latch_pin_ev;
    logic [3:0] src_ev;

    assign fb_up_ev     = pin_ev_r[0];
    assign fb_dn_ev     = pin_ev_r[1];
    assign aux_ev       = pin_ev_r[2];
    assign latch_pin_ev = pin_ev_r[3];
    assign src_ev       = {aux_ev, fb_up_ev | fb_dn_ev, drive_pulse, 1'b0};

    // Reference tick divider; mclk is twice the reference rate
    logic [3:0] ref_div_r;
    logic       ref_tick;

    assign ref_tick = (ref_div_r == 4'(`ACCU_REF_DIV - 1));

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ref_div_r <= 4'h0;
        end else begin
            ref_div_r <= ref_tick ? 4'h0 : ref_div_r + 4'h1;
        end
    end

    // Shared write decodes
    logic       wr_status;
    logic       wr_latch_cmd;

    assign wr_status    = reg_wr && (reg_addr == `ACCU_ADDR_STATUS);
    assign wr_latch_cmd = reg_wr && (reg_addr == `ACCU_ADDR_LATCH_CMD);

    // Per-counter views for the read mux and the output stage
    accu_pkg::accu_word_t cnt_w   [4];
    accu_pkg::accu_word_t lat_w   [4];
    accu_pkg::accu_word_t cmp_w   [4][3];
    accu_pkg::accu_word_t max_w   [4];
    accu_pkg::accu_word_t pre_w   [4];
    logic [`ACCU_CTL_W-1:0] ctl_w [4];
    logic [3:0]           irq_w;
    logic [2:0]           hit_w   [4];
    logic [3:0]           slow_w;
    logic [3:0]           fast_w;
    accu_pkg::accu_word_t meas_w;

    genvar gi;
    genvar gk;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ctr
            accu_pkg::accu_word_t   cnt_r;
            accu_pkg::accu_word_t   cnt_nxt;
            accu_pkg::accu_word_t   lat_r;
            accu_pkg::accu_word_t   max_r;
            accu_pkg::accu_word_t   pre_r;
            accu_pkg::accu_word_t   cval;
            accu_pkg::accu_word_t   inc_val;
            accu_pkg::accu_word_t   dec_val;
            logic [`ACCU_CTL_W-1:0] ctl_r;
            logic                   chg_r;
            logic                   chg_nxt;
            logic                   irq_r;
            logic [2:0]             hit_r;
            logic [2:0]             match;
            logic                   grp_sel;
            logic                   wr_cnt;
            logic                   wr_max;
            logic                   wr_pre;
            logic                   wr_ctl;
            logic                   lat_ev;
            logic                   step_up;
            logic                   step_dn;
            logic                   ring_on;
            logic                   src_a_ev;
            logic                   src_b_ev;
            logic                   per_restart;
            logic                   per_timer;
            accu_pkg::accu_stop_e   stop_mode;

            assign grp_sel  = reg_wr && (reg_addr[5:3] == 3'(gi));
            assign wr_cnt   = grp_sel && (reg_addr[2:0] == `ACCU_OFS_CNT);
            assign wr_max   = grp_sel && (reg_addr[2:0] == `ACCU_OFS_MAX);
            assign wr_pre   = grp_sel && (reg_addr[2:0] == `ACCU_OFS_PRESET);
            assign wr_ctl   = grp_sel && (reg_addr[2:0] == `ACCU_OFS_CTL);
            assign src_a_ev = src_ev[ctl_r[`ACCU_CTL_SRCA_LSB +: 2]];
            assign src_b_ev = src_ev[ctl_r[`ACCU_CTL_SRCB_LSB +: 2]];
            assign stop_mode = accu_pkg::accu_stop_e'(ctl_r[`ACCU_CTL_STOP_LSB +: 2]);
            // Software latch or, when allowed, the latch pin
            assign lat_ev   = (wr_latch_cmd && reg_wdata[gi])
                            || (ctl_r[`ACCU_CTL_LPIN_BIT] && latch_pin_ev);
            // Ring wrap only on the three pulse counters
            assign ring_on  = ctl_r[`ACCU_CTL_RING_BIT] && (gi != 3);
            assign inc_val  = (ring_on && cnt_r == max_r) ? `ACCU_RST_WORD : cnt_r + 32'h1;
            assign dec_val  = (ring_on && cnt_r == `ACCU_RST_WORD) ? max_r : cnt_r - 32'h1;

            // Count step sources differ by counter
            if (gi == 0) begin : g_cmd
                assign step_up = drive_pulse && drive_dir;
                assign step_dn = drive_pulse && !drive_dir;
            end else if (gi == 1) begin : g_act
                assign step_up = fb_up_ev && !fb_dn_ev;
                assign step_dn = fb_dn_ev && !fb_up_ev;
            end else if (gi == 2) begin : g_dif
                // A source of none never fires, leaving a single-source counter
                assign step_up = src_a_ev && !src_b_ev;
                assign step_dn = src_b_ev && !src_a_ev;
            end else begin : g_per
                assign step_up = ref_tick;
                assign step_dn = 1'b0;
            end

            // Period counter compares the finished measurement unless in timer mode
            if (gi == 3) begin : g_meas
                accu_pkg::accu_word_t meas_r;
                logic                 timer_mode;
                logic                 meas_edge;
                assign timer_mode = (ctl_r[`ACCU_CTL_SRCA_LSB +: 2] == `ACCU_SRC_NONE);
                assign meas_edge  = ctl_r[`ACCU_CTL_EN_BIT] && !timer_mode && src_a_ev;
                assign cval       = timer_mode ? cnt_r : meas_r;
                assign meas_w     = meas_r;
                assign per_restart = meas_edge;
                assign per_timer   = timer_mode;
                always_ff @(posedge mclk) begin
                    if (!rst_b) begin
                        meas_r <= `ACCU_RST_WORD;
                    end else if (meas_edge) begin
                        meas_r <= cnt_r;
                    end
                end
            end else begin : g_nomeas
                assign cval = cnt_r;
                assign per_restart = 1'b0;
                assign per_timer   = 1'b0;
            end

            // Comparators; a hit counts only right after the compared value moved
            for (gk = 0; gk < 3; gk = gk + 1) begin : g_cmp
                accu_pkg::accu_word_t cmp_r;
                logic                 wr_cmp;
                assign wr_cmp     = grp_sel && (reg_addr[2:0] == 3'(`ACCU_OFS_CMP0 + gk));
                assign match[gk]  = chg_r && ctl_r[`ACCU_CTL_CMPEN_LSB + gk]
                                  && (cval == cmp_r);
                assign cmp_w[gi][gk] = cmp_r;
                always_ff @(posedge mclk) begin
                    if (!rst_b) begin
                        cmp_r <= `ACCU_RST_WORD;
                    end else if (wr_cmp) begin
                        cmp_r <= reg_wdata;
                    end
                end
            end

            // Next count: latch clear, then first-comparator action, then software, then pulses
            always_comb begin
                cnt_nxt = cnt_r;
                chg_nxt = 1'b0;
                if (lat_ev && ctl_r[`ACCU_CTL_LCLR_BIT]) begin
                    cnt_nxt = `ACCU_RST_WORD;
                end else if (match[0] && ctl_r[`ACCU_CTL_RELOAD_BIT]) begin
                    cnt_nxt = pre_r;
                end else if (match[0] && ctl_r[`ACCU_CTL_ACLR_BIT] && (gi != 0)) begin
                    cnt_nxt = `ACCU_RST_WORD;
                end else if (wr_cnt) begin
                    cnt_nxt = reg_wdata;
                end else if (per_restart) begin
                    cnt_nxt = `ACCU_RST_WORD;
                    chg_nxt = 1'b1;
                end else if (ctl_r[`ACCU_CTL_EN_BIT] && step_up) begin
                    cnt_nxt = inc_val;
                    chg_nxt = (gi != 3) || per_timer;
                end else if (ctl_r[`ACCU_CTL_EN_BIT] && step_dn) begin
                    cnt_nxt = dec_val;
                    chg_nxt = 1'b1;
                end
            end

            // Counter, change flag and setup registers
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    cnt_r <= `ACCU_RST_WORD;
                    chg_r <= 1'b0;
                    ctl_r <= `ACCU_RST_CTL;
                    max_r <= `ACCU_RST_WORD;
                    pre_r <= `ACCU_RST_WORD;
                end else begin
                    cnt_r <= cnt_nxt;
                    chg_r <= chg_nxt;
                    ctl_r <= wr_ctl ? reg_wdata[`ACCU_CTL_W-1:0] : ctl_r;
                    max_r <= wr_max ? reg_wdata : max_r;
                    pre_r <= wr_pre ? reg_wdata : pre_r;
                end
            end

            // Latch holds the pre-clear value until the next latch event
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    lat_r <= `ACCU_RST_WORD;
                end else if (lat_ev) begin
                    lat_r <= cnt_r;
                end
            end

            // Sticky flags; a hit in the clearing cycle wins over the clear
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    irq_r <= 1'b0;
                    hit_r <= 3'h0;
                end else begin
                    irq_r <= (|match) || (irq_r && !(wr_status && reg_wdata[gi]));
                    hit_r <= match | (hit_r & ~({3{wr_status}}
                           & reg_wdata[`ACCU_STAT_HIT_LSB + 3*gi +: 3]));
                end
            end

            assign cnt_w[gi]  = cnt_r;
            assign lat_w[gi]  = lat_r;
            assign max_w[gi]  = max_r;
            assign pre_w[gi]  = pre_r;
            assign ctl_w[gi]  = ctl_r;
            assign irq_w[gi]  = irq_r;
            assign hit_w[gi]  = hit_r;
            assign slow_w[gi] = (|match) && (stop_mode == accu_pkg::accu_stop_slow);
            assign fast_w[gi] = (|match) && (stop_mode == accu_pkg::accu_stop_fast);
        end
    endgenerate

    // Read mux; reads have no side effect on any counter or latch
    logic [2:0]           rd_grp;
    logic [2:0]           rd_ofs;
    accu_pkg::accu_word_t rd_mux;

    assign rd_grp = reg_addr[5:3];
    assign rd_ofs = reg_addr[2:0];

    always_comb begin
        rd_mux = `ACCU_RST_WORD;
        if (reg_addr == `ACCU_ADDR_STATUS) begin
            rd_mux = {16'h0000, hit_w[3], hit_w[2], hit_w[1], hit_w[0], irq_w};
        end else if (reg_addr == `ACCU_ADDR_PERIOD_MEAS) begin
            rd_mux = meas_w;
        end else if (reg_addr[5]) begin
            rd_mux = `ACCU_RST_WORD;
        end else if (rd_ofs == `ACCU_OFS_CNT) begin
            rd_mux = cnt_w[rd_grp[1:0]];
        end else if (rd_ofs == `ACCU_OFS_LATCH) begin
            rd_mux = lat_w[rd_grp[1:0]];
        end else if (rd_ofs == `ACCU_OFS_MAX) begin
            rd_mux = max_w[rd_grp[1:0]];
        end else if (rd_ofs == `ACCU_OFS_PRESET) begin
            rd_mux = pre_w[rd_grp[1:0]];
        end else if (rd_ofs == `ACCU_OFS_CTL) begin
            rd_mux = {17'h00000, ctl_w[rd_grp[1:0]]};
        end else begin
            rd_mux = cmp_w[rd_grp[1:0]][2'(rd_ofs - `ACCU_OFS_CMP0)];
        end
    end

    // Output stage: read data one cycle after the strobe, stop requests one cycle wide
    logic slow_stop_r;
    logic fast_stop_r;
    accu_pkg::accu_word_t rdata_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_r     <= `ACCU_RST_WORD;
            slow_stop_r <= 1'b0;
            fast_stop_r <= 1'b0;
        end else begin
            rdata_r     <= reg_rd ? rd_mux : `ACCU_RST_WORD;
            slow_stop_r <= |slow_w;
            fast_stop_r <= |fast_w;
        end
    end

    assign reg_rdata                 = rdata_r;
    assign slow_stop                 = slow_stop_r;
    assign fast_stop                 = fast_stop_r;
    assign cmd_position_match_irq    = irq_w[0];
    assign actual_position_match_irq = irq_w[1];
    assign difference_match_irq      = irq_w[2];
    assign period_match_irq          = irq_w[3];

endmodule : accu_top

`default_nettype wire

// [testbench/accu_top_assertions.sv]
`include "accu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// Port-level watch of the counting unit; one clock, so one default clocking
module accu_top_checker (
    input wire logic                    mclk,
    input wire logic                    rst_b,
    input wire logic [`ACCU_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    input wire logic                    drive_pulse,
    input wire logic                    fb_up_pin,
    input wire logic                    fb_dn_pin,
    input wire logic                    cmd_position_match_irq,
    input wire logic                    actual_position_match_irq,
    input wire logic                    difference_match_irq,
    input wire logic                    period_match_irq,
    input wire logic                    slow_stop,
    input wire logic                    fast_stop
);
    // Helper nets so that the sampled-value calls see plain signals
    wire       stat_wr = reg_wr && reg_addr == `ACCU_ADDR_STATUS;
    wire       clr_cmd = stat_wr && reg_wdata[0];
    wire       clr_act = stat_wr && reg_wdata[1];
    wire       clr_per = stat_wr && reg_wdata[3];
    wire       fb_any  = fb_up_pin || fb_dn_pin;
    wire [3:0] irq_vec = {period_match_irq, difference_match_irq, actual_position_match_irq, cmd_position_match_irq};
    wire       irq_any = |irq_vec;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data seen outside its cycle");
    a_cmd_cause: assert property ($rose(cmd_position_match_irq) |-> $past(drive_pulse, 2))
        else $error("commanded match without a drive pulse two cycles before");
    // Synchroniser plus filter delay; pins are two cycles wide, so a small spread
    a_act_cause: assert property ($rose(actual_position_match_irq) |->
        $past(fb_any, 6) || $past(fb_any, 7) || $past(fb_any, 8))
        else $error("actual match without a feedback edge");
    a_stop_slow: assert property (slow_stop |-> irq_any)
        else $error("slow stop without a match flag");
    a_stop_fast: assert property (fast_stop |-> irq_any)
        else $error("fast stop without a match flag");
    a_cmd_clear: assert property (clr_cmd && !drive_pulse && !$past(drive_pulse)
        && !$past(drive_pulse, 2) |=> !cmd_position_match_irq)
        else $error("commanded flag not cleared by software");
    a_stat_mirror: assert property (reg_rd && reg_addr == `ACCU_ADDR_STATUS
        |=> reg_rdata[3:0] == $past(irq_vec))
        else $error("status read differs from flags");
    a_cmd_sticky: assert property ($fell(cmd_position_match_irq) |-> $past(clr_cmd))
        else $error("commanded flag dropped by itself");
    a_act_sticky: assert property ($fell(actual_position_match_irq) |-> $past(clr_act))
        else $error("actual flag dropped by itself");
    a_per_sticky: assert property ($fell(period_match_irq) |-> $past(clr_per))
        else $error("period flag dropped by itself");

    c_slow: cover property (slow_stop);
    c_fast: cover property (fast_stop);
    c_diff: cover property ($rose(difference_match_irq));
    c_per: cover property ($rose(period_match_irq));
endmodule : accu_top_checker

bind accu_top accu_top_checker chk_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_pulse(drive_pulse), .fb_up_pin(fb_up_pin),
    .fb_dn_pin(fb_dn_pin), .cmd_position_match_irq(cmd_position_match_irq),
    .actual_position_match_irq(actual_position_match_irq), .difference_match_irq(difference_match_irq),
    .period_match_irq(period_match_irq), .slow_stop(slow_stop), .fast_stop(fast_stop));
`default_nettype wire

// [testbench/accu_pulse_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Pulse generator and encoder stand-in; every pin but drive_dir idles low between pulses
module accu_pulse_model (
    input  wire logic mclk,
    output logic      drive_pulse,
    output logic      drive_dir,
    output logic      fb_up_pin,
    output logic      fb_dn_pin,
    output logic      aux_pulse_pin,
    output logic      latch_pin
);
    logic [3:0] pins;

    assign {latch_pin, aux_pulse_pin, fb_dn_pin, fb_up_pin} = pins;

    // Quiet at time zero
    initial begin
        drive_pulse = 1'b0;
        drive_dir   = 1'b0;
        pins        = 4'h0;
    end

    // Drive pulses are single cycles with a gap, direction held alongside
    task automatic drive(input int n, input logic dir);
        drive_dir <= dir;
        repeat (n) begin
            drive_pulse <= 1'b1;
            @(posedge mclk);
            drive_pulse <= 1'b0;
            @(posedge mclk);
        end
    endtask : drive

    // Async pins stay high two cycles so the synchroniser cannot miss them
    task automatic pin(input int k);
        pins <= 4'(1 << k);
        repeat (2) @(posedge mclk);
        pins <= 4'h0;
        repeat (8) @(posedge mclk);
    endtask : pin
endmodule : accu_pulse_model
`default_nettype wire

// [testbench/testbench.sv]
`include "accu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                    mclk;
    logic                    rst_b;
    logic [`ACCU_ADDR_W-1:0] reg_addr;
    logic [31:0]             reg_wdata;
    logic [31:0]             reg_rdata;
    logic [31:0]             d;
    logic [31:0]             v;
    logic                    reg_wr;
    logic                    reg_rd;
    logic                    drive_pulse;
    logic                    drive_dir;
    logic                    fb_up_pin;
    logic                    fb_dn_pin;
    logic                    aux_pulse_pin;
    logic                    latch_pin;
    logic [3:0]              irq;
    logic                    slow_stop;
    logic                    fast_stop;
    int                      errors;
    int                      compares;
    int                      nslow;
    int                      nfast;

    accu_top uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_pulse(drive_pulse), .drive_dir(drive_dir),
        .fb_up_pin(fb_up_pin), .fb_dn_pin(fb_dn_pin), .aux_pulse_pin(aux_pulse_pin), .latch_pin(latch_pin),
        .cmd_position_match_irq(irq[0]), .actual_position_match_irq(irq[1]), .difference_match_irq(irq[2]),
        .period_match_irq(irq[3]), .slow_stop(slow_stop), .fast_stop(fast_stop));
    accu_pulse_model pm (.mclk(mclk), .drive_pulse(drive_pulse), .drive_dir(drive_dir), .fb_up_pin(fb_up_pin),
        .fb_dn_pin(fb_dn_pin), .aux_pulse_pin(aux_pulse_pin), .latch_pin(latch_pin));

    // 40 MHz clock
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // Stop pulses counted as they pass, since they last one cycle only
    always @(posedge mclk) begin
        if (slow_stop === 1'b1) nslow++;
        if (fast_stop === 1'b1) nfast++;
    end

    // Strobe drops a cycle before return, so back-to-back calls never reassign it in one step
    task automatic wr(input logic [5:0] a, input logic [31:0] x);
        reg_addr  <= a;
        reg_wdata <= x;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] x);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(posedge mclk);
        x = reg_rdata;
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(d, exp);
    endtask : rchk

    task automatic wrap_up;
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Whole sequence needs under 1000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rchk(6'h07, 32'h0);
        rchk(`ACCU_ADDR_STATUS, 32'h0);
        wr(6'h3f, 32'hffff_ffff);
        rchk(6'h3f, 32'h0);
        // Commanded counter: up to the match with slow stop, then below zero
        wr(6'h02, 32'h2);
        wr(6'h07, 32'ha1);
        pm.drive(2, 1'b1);
        rchk(6'h00, 32'h2);
        rchk(`ACCU_ADDR_STATUS, 32'h11);
        chk(irq, 32'h1);
        chk(nslow, 1);
        pm.drive(3, 1'b0);
        rchk(6'h00, 32'hffff_ffff);
        rchk(`ACCU_ADDR_STATUS, 32'h11);
        wr(`ACCU_ADDR_STATUS, 32'h11);
        rchk(`ACCU_ADDR_STATUS, 32'h0);
        // Reload on first comparator; auto clear ignored on this counter
        wr(6'h02, 32'h1);
        wr(6'h06, 32'h10);
        wr(6'h07, 32'h85);
        pm.drive(2, 1'b1);
        rchk(6'h00, 32'h10);
        wr(6'h07, 32'h89);
        wr(6'h00, 32'h0);
        pm.drive(1, 1'b1);
        rchk(6'h00, 32'h1);
        // Software latch holds while the count moves on
        wr(`ACCU_ADDR_LATCH_CMD, 32'h1);
        rchk(6'h01, 32'h1);
        pm.drive(1, 1'b1);
        rchk(6'h01, 32'h1);
        rchk(6'h00, 32'h2);
        // Actual counter with fast stop, then pin latch with clear
        wr(`ACCU_ADDR_STATUS, 32'hffff);
        wr(6'h0a, 32'h1);
        wr(6'h0f, 32'hc1);
        pm.pin(0);
        rchk(6'h08, 32'h1);
        rchk(`ACCU_ADDR_STATUS, 32'h82);
        chk(irq, 32'h2);
        chk(nfast, 1);
        pm.pin(1);
        pm.pin(0);
        pm.pin(0);
        wr(6'h0f, 32'h4011);
        pm.pin(3);
        rchk(6'h09, 32'h2);
        rchk(6'h08, 32'h0);
        rchk(6'h09, 32'h2);
        // Difference: drive pulses up, feedback down
        wr(`ACCU_ADDR_STATUS, 32'hffff);
        wr(6'h12, 32'h2);
        wr(6'h17, 32'h2481);
        pm.drive(3, 1'b1);
        pm.pin(0);
        rchk(6'h10, 32'h2);
        rchk(`ACCU_ADDR_STATUS, 32'h404);
        chk(irq, 32'h4);
        wr(6'h17, 32'h489);
        wr(6'h10, 32'h0);
        pm.drive(2, 1'b1);
        rchk(6'h10, 32'h0);
        // Single source with ring maximum of two
        wr(6'h15, 32'h2);
        wr(6'h17, 32'hc03);
        wr(6'h10, 32'h0);
        repeat (3) pm.pin(2);
        rchk(6'h10, 32'h0);
        pm.pin(2);
        rchk(6'h10, 32'h1);
        // Period counter as timer: one tick per two cycles
        wr(6'h1a, 32'h5);
        wr(6'h1f, 32'h81);
        repeat (20) @(posedge mclk);
        rd(`ACCU_ADDR_STATUS, d);
        chk({d[13], d[3]}, 2'b11);
        chk(irq[3], 1'b1);
        rd(6'h18, v);
        repeat (18) @(posedge mclk);
        rd(6'h18, d);
        chk(d - v, 32'd10);
        // Timer is far past its comparator, so the clear must stick
        wr(`ACCU_ADDR_STATUS, 32'h8);
        chk(irq[3], 1'b0);
        // Measured period of drive pulses forty cycles apart, edge phase may cost one tick
        wr(6'h1f, 32'h401);
        pm.drive(1, 1'b1);
        repeat (38) @(posedge mclk);
        pm.drive(1, 1'b1);
        rd(`ACCU_ADDR_PERIOD_MEAS, d);
        chk({31'h0, d == 32'd19 || d == 32'd20}, 32'h1);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
